/* rtl/waveform_update_timing_engine.sv */
// Functional notes
// - Each sample clock pulse converts once
// - Sample clock: external signal or divider
// - Divider gives one pulse per N
// - Timebase: internal oscillator or external source
// - Inputs synchronized on sync timebase first
// - Generation waits for the start trigger
// - Only the selected start trigger starts
// - Pause gate low pauses generation
// - Pause source: software or external signal
// - Terminals carry triggers and exports
// - Terminal inputs buffered before multiplexers
// - Sync timebase is inverted timebase
// - Pause sampled on sync timebase rise
// - Exported sample clock active low
// - Start export is unregistered selected start
`include "wavegen_defines.svh"
module waveform_update_timing_engine
(
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  // Programmable function terminals
  input  wire logic [`PTERM_N-1:0]      prog_term_in,
  output wire logic [`PTERM_N-1:0]      prog_term_out,
  output wire logic [`PTERM_N-1:0]      prog_term_oe,
  input  wire logic [`PTERM_N*2-1:0]    prog_term_route,
  // Sync bus terminals
  input  wire logic [`SBUS_N-1:0]       sync_in,
  output wire logic [`SBUS_N-1:0]       sync_out,
  output wire logic [`SBUS_N-1:0]       sync_oe,
  input  wire logic [`SBUS_N*2-1:0]     sync_route,
  // Star trigger terminal
  input  wire logic                     star_in,
  // Source selection
  input  wire logic                     tb_src_ext,
  input  wire logic [`SEL_W-1:0]        tb_sel,
  input  wire logic                     clk_src_ext,
  input  wire logic [`SEL_W-1:0]        clk_sel,
  input  wire logic [`SEL_W-1:0]        start_sel,
  input  wire logic [`SEL_W-1:0]        pause_sel,
  input  wire logic                     pause_en,
  input  wire logic [`CNT_W-1:0]        interval,
  // Software commands
  input  wire logic                     arm,
  input  wire logic                     stop,
  input  wire logic                     sw_start,
  input  wire logic                     sw_pause,
  // DAC and status
  output wire logic                     dac_convert,
  output wire logic                     sample_clk_n,
  output wire logic                     armed,
  output wire logic                     running,
  output wire logic                     start_export
);
  import wavegen_pkg::*;

  // ----------------------------------------------------------------
  // Internal bus source picker
  // ----------------------------------------------------------------
  function automatic logic pick(input logic [`BUS_W-1:0] bus,
                                input logic [`SEL_W-1:0] sel,
                                input logic              sw);
    logic r;
    r = 1'b0;
    if (sel == `SEL_SW) begin
      r = sw;
    end else if (sel < `SEL_W'(`BUS_W)) begin
      r = bus[sel];
    end
    return r;
  endfunction

  function automatic logic route_drive(input logic [`ROUTE_W-1:0] rt,
                                       input logic st_trig,
                                       input logic ps,
                                       input logic sc_n);
    logic r;
    r = 1'b0;
    case (rt)
      `ROUTE_STRT: r = st_trig;
      `ROUTE_PAUS: r = ps;
      `ROUTE_SCLK: r = sc_n;
      default:     r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Input buffers
  // ----------------------------------------------------------------
  logic [`BUS_W-1:0] bus;
  logic [`BUS_W-1:0] term_raw;

  assign term_raw = {star_in, sync_in, prog_term_in};

  genvar gi;
  generate
    for (gi = 0; gi < `BUS_W; gi++) begin : g_buf
      input_buffer_sync u_buf (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (term_raw[gi]),
        .level    (bus[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Selection multiplexers
  // ----------------------------------------------------------------
  engine_regs_t q;
  engine_regs_t next_q;
  logic         tb;
  logic         tb_rise;
  logic         tb_fall;
  logic         sel_start;
  logic         sel_pause;
  logic         sel_clk;
  logic         gen_on;

  assign tb        = tb_src_ext ? pick(bus, tb_sel, 1'b0) : q.tb_int;
  assign tb_rise   = tb & ~q.tb_prev;
  // sync timebase edge is timebase fall
  assign tb_fall   = ~tb & q.tb_prev;
  assign sel_start = pick(bus, start_sel, sw_start);
  assign sel_pause = pick(bus, pause_sel, sw_pause);
  assign sel_clk   = pick(bus, clk_sel, 1'b0);
  assign gen_on    = (q.st == ST_RUN) && (!pause_en || q.pause_q);

  // ----------------------------------------------------------------
  // Engine next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q         = q;
    next_q.tb_int  = ~q.tb_int;
    next_q.tb_prev = tb;
    next_q.convert = 1'b0;
    if (q.st == ST_ARMED && sel_start) begin
      next_q.start_pend = 1'b1;
    end
    if (tb_fall) begin
      next_q.start_q  = q.start_pend | (q.st == ST_ARMED && sel_start);
      next_q.pause_q  = sel_pause;
      next_q.extclk_q = sel_clk;
    end
    if (tb_rise) begin
      next_q.extclk_prev = q.extclk_q;
      next_q.sclk_n      = 1'b1;
    end
    case (q.st)
      ST_IDLE: begin
        if (arm && !stop) begin
          next_q.st         = ST_ARMED;
          next_q.cnt        = interval;
          next_q.start_pend = 1'b0;
          next_q.start_q    = 1'b0;
        end
      end
      ST_ARMED: begin
        if (stop) begin
          next_q.st = ST_IDLE;
        end else if (tb_rise && q.start_q) begin
          next_q.st         = ST_RUN;
          next_q.start_pend = 1'b0;
          next_q.start_q    = 1'b0;
        end
      end
      ST_RUN: begin
        if (stop) begin
          next_q.st = ST_IDLE;
        end
      end
      default: next_q.st = ST_IDLE;
    endcase
    if (gen_on && tb_rise && !stop) begin
      if (clk_src_ext) begin
        if (q.extclk_q && !q.extclk_prev) begin
          next_q.convert = 1'b1;
          next_q.sclk_n  = 1'b0;
        end
      end else if (q.cnt <= `CNT_ONE) begin
        next_q.cnt     = interval;
        next_q.convert = 1'b1;
        next_q.sclk_n  = 1'b0;
      end else begin
        next_q.cnt = q.cnt - `CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q             <= '0;
      q.st          <= ST_IDLE;
      q.cnt         <= `CNT_RST;
      q.sclk_n      <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and terminal exports
  // ----------------------------------------------------------------
  // one convert per pulse
  assign dac_convert  = q.convert;
  assign sample_clk_n = q.sclk_n;
  assign armed        = (q.st == ST_ARMED);
  assign running      = gen_on;
  assign start_export = sel_start;

  generate
    for (gi = 0; gi < `PTERM_N; gi++) begin : g_prog
      assign prog_term_oe[gi]  = prog_term_route[gi*2 +: 2] != `ROUTE_OFF;
      assign prog_term_out[gi] = route_drive(prog_term_route[gi*2 +: 2],
                                           sel_start, sel_pause, q.sclk_n);
    end
    for (gi = 0; gi < `SBUS_N; gi++) begin : g_sbus
      assign sync_oe[gi]  = sync_route[gi*2 +: 2] != `ROUTE_OFF;
      assign sync_out[gi] = route_drive(sync_route[gi*2 +: 2], sel_start,
                                        sel_pause, q.sclk_n);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_convert_when_on: assert property (
    dac_convert |-> $past(gen_on) && $past(tb_rise))
    else $error("convert without running timebase tick");

  a_low_with_convert: assert property (
    dac_convert |-> !sample_clk_n ##1 !sample_clk_n)
    else $error("exported clock not low with convert");

  a_div_no_early: assert property (
    (gen_on && tb_rise && !stop && !clk_src_ext && q.cnt > `CNT_ONE)
    |=> !dac_convert && q.cnt == $past(q.cnt) - `CNT_ONE)
    else $error("divider fired before terminal count");

  a_div_reload: assert property (
    (gen_on && tb_rise && !stop && !clk_src_ext && q.cnt <= `CNT_ONE)
    |=> dac_convert && q.cnt == $past(interval))
    else $error("divider did not reload at terminal count");

  a_hold_paused: assert property (
    (q.st == ST_RUN && !gen_on && !stop) |=> q.cnt == $past(q.cnt))
    else $error("counter moved while paused");

  a_wait_start: assert property (
    (q.st != ST_RUN) |=> !dac_convert)
    else $error("convert before start");

  a_start_latched: assert property (
    (q.st == ST_ARMED && sel_start && !stop && !tb_rise) |=> q.start_pend)
    else $error("selected start lost");

  a_pause_sample: assert property (
    tb_fall |=> q.pause_q == $past(sel_pause))
    else $error("pause not sampled on sync edge");

  a_pause_gate: assert property (
    (q.st == ST_RUN && pause_en && !q.pause_q) |=> !dac_convert)
    else $error("convert while pause gate low");

  a_run_holds: assert property (
    (q.st == ST_RUN && !stop) [*2] |=> q.st == ST_RUN)
    else $error("run state left without stop");

  c_convert:  cover property (dac_convert ##[1:40] dac_convert);
  c_start:    cover property (q.st == ST_ARMED ##1 q.st == ST_RUN);
  c_paused:   cover property (q.st == ST_RUN && pause_en && !q.pause_q);

endmodule

/* common/wavegen_defines.svh */
`ifndef WAVEGEN_DEFINES_SVH
`define WAVEGEN_DEFINES_SVH

// ------------------------------------------------------------------
// Terminal counts and internal bus
// ------------------------------------------------------------------
`define PTERM_N    16
`define SBUS_N     8
`define BUS_W      25
`define SBUS_POS   16
`define STAR_POS   24

// ------------------------------------------------------------------
// Source selection codes
// ------------------------------------------------------------------
`define SEL_W      5
`define SEL_SW     5'h1f

// ------------------------------------------------------------------
// Update interval counter
// ------------------------------------------------------------------
`define CNT_W      24
`define CNT_RST    24'h000000
`define CNT_ONE    24'h000001

// ------------------------------------------------------------------
// Terminal export routes, two bits per terminal
// ------------------------------------------------------------------
`define ROUTE_W    2
`define ROUTE_OFF  2'h0
`define ROUTE_STRT 2'h1
`define ROUTE_PAUS 2'h2
`define ROUTE_SCLK 2'h3

`endif

/* common/wavegen_pkg.sv */
`include "wavegen_defines.svh"

package wavegen_pkg;

  // ----------------------------------------------------------------
  // Generation states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_RUN
  } gen_state_t;

  // ----------------------------------------------------------------
  // Engine state
  // ----------------------------------------------------------------
  typedef struct packed {
    gen_state_t           st;
    logic [`CNT_W-1:0]    cnt;
    logic                 tb_int;
    logic                 tb_prev;
    logic                 start_pend;
    logic                 start_q;
    logic                 pause_q;
    logic                 extclk_q;
    logic                 extclk_prev;
    logic                 convert;
    logic                 sclk_n;
  } engine_regs_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_regs_t;

endpackage

/* rtl/input_buffer_sync.sv */
module input_buffer_sync
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Terminal side
  input  wire logic async_in,
  // Internal bus side
  output wire logic level
);
  import wavegen_pkg::*;

  sync_regs_t q;
  sync_regs_t next_q;

  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_q    = q;
    next_q.s1 = async_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    if (q.s2 == q.s3) begin
      next_q.level = q.s3;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level = q.level;

endmodule

/* bench/dac_terminal_model.sv */
module dac_terminal_model #(
  parameter int BURST = 6
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Converter side
  input  wire logic dac_convert,
  // Terminal side
  input  wire logic ext_go,
  output logic      ext_clk,
  output int        conv_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  int left;
  int ph;
  always @(posedge clk_sys) begin
    if (!rst_n)
      conv_cnt <= 0;
    else if (dac_convert === 1'b1)
      conv_cnt <= conv_cnt + 1;
  end
  // terminal clock bursts, idle low between them
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      left <= 0;
      ph <= 0;
      ext_clk <= 1'b0;
    end else if (ext_go) begin
      left <= BURST;
      ph <= 0;
    end else if (left > 0) begin
      ph <= (ph + 1) % 8;
      ext_clk <= (ph < 4);
      if (ph == 7)
        left <= left - 1;
    end else begin
      ext_clk <= 1'b0;
    end
  end
endmodule

/* bench/waveform_update_timing_engine_bench.sv */
`include "wavegen_defines.svh"

module waveform_update_timing_engine_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import wavegen_pkg::*;
  logic clk_sys = 0;
  logic rst_n = 0;
  logic [`PTERM_N-1:0] prog_term_in = '0;
  logic [`PTERM_N*2-1:0] prog_term_route = '0;
  logic [`SBUS_N*2-1:0] sync_route = '0;
  logic star_in = 0, tb_src_ext = 0, clk_src_ext = 0, pause_en = 0;
  logic star_run = 0;
  logic [2:0] star_div = '0;
  logic [`ROUTE_W-1:0] rt;
  logic [`SEL_W-1:0] tb_sel = '0, clk_sel = '0;
  logic [`SEL_W-1:0] start_sel = `SEL_SW, pause_sel = `SEL_SW;
  logic [`CNT_W-1:0] interval = `CNT_ONE;
  logic arm = 0, stop = 0, sw_start = 0, sw_pause = 1, ext_go = 0;
  logic [`PTERM_N-1:0] prog_term_out, prog_term_oe;
  logic [`SBUS_N-1:0] sync_out, sync_oe;
  logic dac_convert, sample_clk_n, armed, running, start_export, ext_clk;
  int conv_cnt, error_cnt = 0, comparisons = 0, cyc = 0, c, c0, k, p;

  waveform_update_timing_engine u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .prog_term_in(prog_term_in),
    .prog_term_out(prog_term_out), .prog_term_oe(prog_term_oe),
    .prog_term_route(prog_term_route),
    .sync_in({{(`SBUS_N-1){1'b0}}, ext_clk}), .sync_out(sync_out),
    .sync_oe(sync_oe), .sync_route(sync_route), .star_in(star_in),
    .tb_src_ext(tb_src_ext), .tb_sel(tb_sel), .clk_src_ext(clk_src_ext),
    .clk_sel(clk_sel), .start_sel(start_sel), .pause_sel(pause_sel),
    .pause_en(pause_en), .interval(interval), .arm(arm), .stop(stop),
    .sw_start(sw_start), .sw_pause(sw_pause), .dac_convert(dac_convert),
    .sample_clk_n(sample_clk_n), .armed(armed), .running(running),
    .start_export(start_export));

  dac_terminal_model u_far (
    .clk_sys(clk_sys), .rst_n(rst_n), .dac_convert(dac_convert),
    .ext_go(ext_go), .ext_clk(ext_clk), .conv_cnt(conv_cnt));

  // Free-running external timebase on the star terminal, 8 cycles a period
  always @(posedge clk_sys) begin
    star_div <= star_div + 3'h1;
    if (star_run)
      star_in <= star_div[2];
  end

  always #5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Checking and run control
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk_bit(string what, logic e, logic g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk_num(string what, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0d seen %0d", what, e, g);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One pulse per N timebase ticks, N of 0 acting as 1
  function automatic logic [31:0] exp_period(logic [`CNT_W-1:0] n,
                                             int tick_len);
    return ((n == '0) ? 32'h1 : 32'(n)) * 32'(tick_len);
  endfunction

  // Level a routed terminal must show for its route code
  function automatic logic exp_drive(logic [`ROUTE_W-1:0] code);
    case (code)
      `ROUTE_STRT: return start_export;
      `ROUTE_PAUS: return sw_pause;
      `ROUTE_SCLK: return sample_clk_n;
      default:     return 1'b0;
    endcase
  endfunction

  // Counts cycles up to the next convert pulse, seen at falling edges
  task automatic wait_conv(output int cnt);
    cnt = 0;
    do begin
      @(negedge clk_sys);
      cnt++;
    end while (dac_convert !== 1'b1 && cnt < 300);
  endtask

  // Stops, re-arms with the chosen start source and pulses sw_start when use_sw is set
  task automatic restart(logic [`SEL_W-1:0] src, logic use_sw);
    tick(1);
    stop <= 1;
    start_sel <= src;
    tick(1);
    stop <= 0;
    arm <= 1;
    tick(1);
    arm <= 0;
    sw_start <= use_sw;
    tick(1);
    sw_start <= 0;
  endtask

  task automatic run_period(logic [`CNT_W-1:0] n, int tick_len);
    interval <= n;
    restart(`SEL_SW, 1'b1);
    wait_conv(c);
    chk_bit("sample_clk_n", 1'b0, sample_clk_n);
    wait_conv(c);
    chk_num("period", exp_period(n, tick_len), c);
    tick(1);
  endtask

  initial begin
    void'($urandom(49606));
    tick(1);
    @(negedge clk_sys);
    chk_bit("reset convert", 1'b0, dac_convert);
    chk_bit("reset sclk", 1'b1, sample_clk_n);
    chk_bit("reset armed", 1'b0, armed);
    tick(1);
    rst_n <= 1;
    // Start without arming must not run
    sw_start <= 1;
    tick(1);
    sw_start <= 0;
    tick(30);
    @(negedge clk_sys);
    chk_bit("idle run", 1'b0, running);
    chk_num("idle conv", 0, conv_cnt);
    tick(1);
    run_period(24'h000000, 2);
    run_period(24'h000001, 2);
    repeat (6) run_period(24'($urandom_range(1, 7)), 2);
    // Pause gating from software level
    run_period(24'h000002, 2);
    pause_en <= 1;
    sw_pause <= 0;
    tick(6);
    @(negedge clk_sys);
    c0 = conv_cnt;
    tick(40);
    @(negedge clk_sys);
    chk_num("paused conv", c0, conv_cnt);
    chk_bit("paused run", 1'b0, running);
    tick(1);
    sw_pause <= 1;
    tick(40);
    @(negedge clk_sys);
    chk_bit("resumed", 1'b1, conv_cnt > c0);
    // Pause gate from a terminal: pin low pauses, high resumes
    p = $urandom_range(0, `PTERM_N - 1);
    tick(1);
    pause_sel <= 5'(p);
    tick(6);
    @(negedge clk_sys);
    c0 = conv_cnt;
    tick(40);
    @(negedge clk_sys);
    chk_num("term paused", c0, conv_cnt);
    tick(1);
    prog_term_in <= 16'h0001 << p;
    tick(40);
    @(negedge clk_sys);
    chk_bit("term resumed", 1'b1, conv_cnt > c0);
    tick(1);
    prog_term_in <= '0;
    pause_sel <= `SEL_SW;
    pause_en <= 0;
    // Terminal start: wrong terminal ignored, chosen one starts
    k = $urandom_range(0, `PTERM_N - 2);
    restart(5'(k), 1'b0);
    prog_term_in <= 16'h0001 << (k + 1);
    tick(10);
    @(negedge clk_sys);
    chk_bit("other start", 1'b0, running);
    tick(1);
    prog_term_in <= 16'h0001 << k;
    tick(6);
    @(negedge clk_sys);
    chk_bit("start_export", 1'b1, start_export);
    tick(6);
    @(negedge clk_sys);
    chk_bit("term run", 1'b1, running);
    tick(1);
    prog_term_in <= '0;
    // Export routes on every terminal
    prog_term_route <= 32'($urandom());
    sync_route <= 16'($urandom());
    @(negedge clk_sys);
    for (int j = 0; j < `PTERM_N; j++) begin
      rt = prog_term_route[2*j +: 2];
      chk_bit("prog_term_oe", rt != `ROUTE_OFF, prog_term_oe[j]);
      chk_bit("prog_term_out", exp_drive(rt), prog_term_out[j]);
    end
    for (int j = 0; j < `SBUS_N; j++) begin
      rt = sync_route[2*j +: 2];
      chk_bit("sync_oe", rt != `ROUTE_OFF, sync_oe[j]);
      chk_bit("sync_out", exp_drive(rt), sync_out[j]);
    end
    // External sample clock on a sync bus terminal
    tick(1);
    prog_term_route <= '0;
    sync_route <= '0;
    clk_src_ext <= 1;
    clk_sel <= 5'(`SBUS_POS);
    restart(`SEL_SW, 1'b1);
    tick(20);
    @(negedge clk_sys);
    c0 = conv_cnt;
    tick(1);
    ext_go <= 1;
    tick(1);
    ext_go <= 0;
    tick(80);
    @(negedge clk_sys);
    chk_num("ext conv", c0 + 6, conv_cnt);
    // External timebase from the star terminal, divided by N
    tick(1);
    clk_src_ext <= 0;
    tb_src_ext <= 1;
    tb_sel <= 5'(`STAR_POS);
    star_run <= 1;
    run_period(24'($urandom_range(1, 7)), 8);
    conclude();
  end
endmodule
